// ==== design/sps_pkg.sv ====
// Purpose: shared constants for the serial peripheral and port pin block
// Assumes: registers reached by word index; byte address is four times index
// Notes:   field positions are bit numbers inside the low data byte
package sps_pkg;
  // register indices
  localparam logic [7:0] REG_CTRL1 = 8'hd0;
  localparam logic [7:0] REG_BAUD  = 8'hd2;
  localparam logic [7:0] REG_STAT  = 8'hd3;
  localparam logic [7:0] REG_DATA  = 8'hd5;
  localparam logic [7:0] REG_PORT  = 8'hd6;
  localparam logic [7:0] REG_DIR   = 8'hd7;
  localparam logic [7:0] REG_PORT_PULLUP_DRIVE_CONTROL = 8'hd9;
  // serial_control_one fields
  localparam int C1_IRQ_EN = 7;
  localparam int C1_ENABLE = 6;
  localparam int C1_MASTER = 4;
  localparam int C1_CPOL   = 3;
  localparam int C1_CPHA   = 2;
  localparam int C1_SSOE   = 1;
  localparam int C1_LSBF   = 0;
  localparam logic [7:0] C1_MASK  = 8'hdf;
  localparam logic [7:0] C1_RESET = 8'h00;
  // serial_status_flags fields
  localparam int ST_DONE = 7;
  localparam int ST_WRITE_COLLISION_FLAG = 6;
  localparam int ST_MODE_FAULT_FLAG = 4;
  // port_pullup_drive_control fields
  localparam int PD_RD_HIGH = 6;
  localparam int PD_RD_MID  = 5;
  localparam int PD_RD_LOW  = 4;
  localparam int PD_PU_HIGH = 2;
  localparam int PD_PU_MID  = 1;
  localparam int PD_PU_LOW  = 0;
  localparam logic [7:0] PD_MASK  = 8'h77;
  localparam logic [7:0] PD_RESET = 8'h00;
  // pin positions
  localparam int PIN_RX0  = 0;
  localparam int PIN_TX0  = 1;
  localparam int PIN_RX1  = 2;
  localparam int PIN_TX1  = 3;
  localparam int PIN_MISO = 4;
  localparam int PIN_MOSI = 5;
  localparam int PIN_SCK  = 6;
  localparam int PIN_SEL  = 7;
  // timing counts
  localparam logic [2:0] BAUD_RESET = 3'h0;
  localparam logic [4:0] EDGE_COUNT = 5'h10;
  localparam logic [2:0] BIT_LAST   = 3'h7;
endpackage : sps_pkg

// ==== design/sps_xfer_if.sv ====
// Purpose: carrier between the register side and the byte shifter
// Assumes: lead and trail are one-cycle pulses on sys_clk
// Notes:   abort holds the bit counter at zero
`timescale 1ns/1ns
`default_nettype none
interface sps_xfer_if;
  logic       load;
  logic [7:0] wdata;
  logic       lead;
  logic       trail;
  logic       cpha;
  logic       lsbf;
  logic       abort;
  logic       sin;
  logic       sout;
  logic       busy;
  logic       done;
  logic [7:0] rx;
  modport ctl (output load, wdata, lead, trail, cpha, lsbf, abort, sin,
               input sout, busy, done, rx);
  modport eng (input load, wdata, lead, trail, cpha, lsbf, abort, sin,
               output sout, busy, done, rx);
endinterface : sps_xfer_if
`default_nettype wire

// ==== design/sps_sync.sv ====
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none
module sps_sync #(
  parameter int W = 8
) (
  // clock
  input  wire logic         clk,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : sps_sync
`default_nettype wire

// ==== design/sps_shifter.sv ====
// Purpose: eight-bit shift register and bit counter of the serial link
// Assumes: edge pulses come from the master divider or the slave clock pin
// Notes:   shift data is not reset, so a reset leaves the byte in place
`timescale 1ns/1ns
`default_nettype none
module sps_shifter (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control side
  sps_xfer_if.eng   x
);
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic       out_q;
  logic       done_q;

  wire       samp     = x.cpha ? x.trail : x.lead;
  wire       shft     = x.cpha ? x.lead : x.trail;
  wire [7:0] sh_next  = x.lsbf ? {x.sin, sh_q[7:1]} : {sh_q[6:0], x.sin};
  wire       out_next = x.lsbf ? sh_q[0] : sh_q[7];
  wire       load_bit = x.lsbf ? x.wdata[0] : x.wdata[7];

  // no reset on purpose: the data byte survives system reset
  always_ff @(posedge clk) begin
    if (x.load) begin
      sh_q <= x.wdata;
    end else if (samp && !x.abort) begin
      sh_q <= sh_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 3'h0;
      out_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (x.load) begin
        out_q <= load_bit;
      end else if (shft && !x.abort) begin
        out_q <= out_next;
      end
      if (x.abort) begin
        cnt_q <= 3'h0;
      end else if (samp && !x.load) begin
        cnt_q  <= cnt_q + 3'h1;
        done_q <= (cnt_q == sps_pkg::BIT_LAST);
      end
    end
  end

  assign x.sout = out_q;
  assign x.busy = (cnt_q != 3'h0);
  assign x.done = done_q;
  assign x.rx   = sh_q;

  chk_eighth_sample_done: assert property (@(posedge clk) disable iff (rst)
    samp && !x.abort && !x.load && cnt_q == 3'h7 |=> x.done && !x.busy)
    else $error("eighth sample did not finish the byte");
endmodule : sps_shifter
`default_nettype wire

// ==== design/sps_port_spi.sv ====
// Purpose: serial peripheral flags, data register and shared eight-pin port
// Assumes: register index on avs_address; one wait cycle per access
// Notes:   sci_* inputs come from the asynchronous serial units on sys_clk
`timescale 1ns/1ns
`default_nettype none
// Contract
// - busy data write dropped, collision flag set
// - collision flag never raises an interrupt
// - status read then data access clears collision
// - master with select pin low sets fault
// - select direction set inhibits fault, flag cleared
// - status read then control write clears fault
// - reads buffered byte, writes load shifter
// - reset keeps serial data contents
// - eight shifts exchange bytes with partner
// - reset makes pins inputs, clears direction
// - port read gives pin or driver level
// - port latch drives only general outputs
// - direction bit zero input, one output
// - receiver two-wire forces bits two, zero input
// - transmitter two-wire forces bits three, one output
// - serial inputs forced; outputs need direction bit
// - slave pin seven is select input
// - fault clears direction bits five to seven
// - reduced drive per pin group
// - group pull-ups only on input pins
// - done flag after eighth clock, cleared
// - interrupt on done or fault when enabled
// - enable reads zero during fault
module sps_port_spi (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register bus
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // port pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pin_pullup_en,
  output logic      [7:0]  pin_drive_reduced,
  // asynchronous serial units
  input  wire logic [1:0]  sci_rx_two_wire,
  input  wire logic [1:0]  sci_tx_two_wire,
  input  wire logic [1:0]  sci_txd,
  output logic      [1:0]  sci_rxd,
  // interrupt request
  output logic             spi_irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] pin_s;
  logic [7:0] ctrl_q;
  logic [2:0] spr_q;
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] port_pullup_drive_control_q;
  logic [7:0] rx_buf_q;
  logic       transfer_done_flag_q;
  logic       write_collision_flag_q;
  logic       mode_fault_flag_q;
  logic       arm_transfer_done_flag_q;
  logic       arm_write_collision_flag_q;
  logic       arm_mode_fault_flag_q;
  logic       m_act_q;
  logic [4:0] hc_q;
  logic [7:0] div_q;
  logic       sck_q;
  logic       sck_p_q;

  sps_xfer_if xf ();

  sps_sync #(.W(8)) u_sync (
    .clk (sys_clk),
    .d   (pin_in),
    .q   (pin_s)
  );

  sps_shifter u_shift (
    .clk (sys_clk),
    .rst (rst),
    .x   (xf)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        req       = avs_read | avs_write;
  wire        commit    = req & ~avs_waitrequest;
  wire        wr_c      = commit & avs_write & avs_byteenable[0];
  wire        rd_c      = commit & avs_read;
  wire [7:0]  wd        = avs_writedata[7:0];
  wire        hit_ctrl  = (avs_address == sps_pkg::REG_CTRL1);
  wire        hit_baud  = (avs_address == sps_pkg::REG_BAUD);
  wire        hit_stat  = (avs_address == sps_pkg::REG_STAT);
  wire        hit_data  = (avs_address == sps_pkg::REG_DATA);
  wire        hit_port  = (avs_address == sps_pkg::REG_PORT);
  wire        hit_dir   = (avs_address == sps_pkg::REG_DIR);
  wire        hit_port_pullup_drive_control = (avs_address == sps_pkg::REG_PORT_PULLUP_DRIVE_CONTROL);
  wire        ctrl_wr   = wr_c & hit_ctrl;
  wire        dir_wr    = wr_c & hit_dir;
  wire        data_acc  = commit & hit_data;

  // mode decode
  wire ie      = ctrl_q[sps_pkg::C1_IRQ_EN];
  wire serial_system_enable     = ctrl_q[sps_pkg::C1_ENABLE];
  wire master_select    = ctrl_q[sps_pkg::C1_MASTER];
  wire cpol    = ctrl_q[sps_pkg::C1_CPOL];
  wire ssoe    = ctrl_q[sps_pkg::C1_SSOE];
  wire spi_on  = serial_system_enable & ~mode_fault_flag_q;
  wire master_select_on = spi_on & master_select;
  wire slv_sel = spi_on & ~master_select & ~pin_s[sps_pkg::PIN_SEL];

  wire xfer_busy = m_act_q | xf.busy;
  wire write_collision_flag_set  = wr_c & hit_data & xfer_busy;
  wire data_load = wr_c & hit_data & ~xfer_busy;

  ////////////////////////////////////////////////////////////////////////
  // read mux
  wire [7:0] ctrl_rd = {ie, spi_on, 1'b0, ctrl_q[4:0]};
  wire [7:0] stat_rd = {transfer_done_flag_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};
  wire [7:0] port_rd = (pin_oe & pin_out) | (~pin_oe & pin_s);
  wire [7:0] rd_val  = hit_ctrl  ? ctrl_rd :
                       hit_baud  ? {5'h00, spr_q} :
                       hit_stat  ? stat_rd :
                       hit_data  ? rx_buf_q :
                       hit_port  ? port_rd :
                       hit_dir   ? dir_q :
                       hit_port_pullup_drive_control ? port_pullup_drive_control_q :
                       8'h00;

  // one wait cycle, then the access commits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, rd_val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  wire       fault    = serial_system_enable & master_select & ~dir_q[sps_pkg::PIN_SEL]
                        & ~pin_s[sps_pkg::PIN_SEL] & ~mode_fault_flag_q;
  wire [7:0] dir_pre  = dir_wr ? wd : dir_q;
  wire [7:0] dir_d    = fault ? {3'h0, dir_pre[4:0]} : dir_pre;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q  <= sps_pkg::C1_RESET;
      spr_q   <= sps_pkg::BAUD_RESET;
      latch_q <= 8'h00;
      dir_q   <= 8'h00;
      port_pullup_drive_control_q <= sps_pkg::PD_RESET;
    end else begin
      dir_q <= dir_d;
      if (ctrl_wr) begin
        ctrl_q <= wd & sps_pkg::C1_MASK;
      end
      if (wr_c && hit_baud) begin
        spr_q <= wd[2:0];
      end
      if (wr_c && hit_port) begin
        latch_q <= wd;
      end
      if (wr_c && hit_port_pullup_drive_control) begin
        port_pullup_drive_control_q <= wd & sps_pkg::PD_MASK;
      end
    end
  end

  // received byte has no reset, like the shifter
  always_ff @(posedge sys_clk) begin
    if (xf.done) begin
      rx_buf_q <= xf.rx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: a setting event wins over a clear in the same cycle
  wire transfer_done_flag_d = xf.done ? 1'b1 : (data_acc & arm_transfer_done_flag_q) ? 1'b0 : transfer_done_flag_q;
  wire write_collision_flag_d = write_collision_flag_set ? 1'b1 : (data_acc & arm_write_collision_flag_q) ? 1'b0 : write_collision_flag_q;
  wire mode_fault_flag_d = fault ? 1'b1 :
                (dir_d[sps_pkg::PIN_SEL] | (ctrl_wr & arm_mode_fault_flag_q)) ? 1'b0 :
                mode_fault_flag_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      transfer_done_flag_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      arm_transfer_done_flag_q <= 1'b0;
      arm_write_collision_flag_q <= 1'b0;
      arm_mode_fault_flag_q <= 1'b0;
      spi_irq    <= 1'b0;
    end else begin
      transfer_done_flag_q  <= transfer_done_flag_d;
      write_collision_flag_q  <= write_collision_flag_d;
      mode_fault_flag_q  <= mode_fault_flag_d;
      // collision flag stays out of the request on purpose
      spi_irq <= ie & (transfer_done_flag_q | mode_fault_flag_q);
      if (rd_c && hit_stat) begin
        arm_transfer_done_flag_q <= transfer_done_flag_q;
        arm_write_collision_flag_q <= write_collision_flag_q;
        arm_mode_fault_flag_q <= mode_fault_flag_q;
      end else begin
        if (data_acc) begin
          arm_transfer_done_flag_q <= 1'b0;
          arm_write_collision_flag_q <= 1'b0;
        end
        if (ctrl_wr) begin
          arm_mode_fault_flag_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master clock: one idle half-period before the first edge
  wire [7:0] half_last = 8'((8'h01 << spr_q) - 8'h01);
  wire       tick      = m_act_q && (div_q == half_last);
  wire       m_edge    = tick && (hc_q != sps_pkg::EDGE_COUNT);
  wire       m_lead    = m_edge & ~hc_q[0];
  wire       m_trail   = m_edge & hc_q[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m_act_q <= 1'b0;
      hc_q    <= 5'h00;
      div_q   <= 8'h00;
      sck_q   <= 1'b0;
      sck_p_q <= 1'b0;
    end else begin
      sck_p_q <= pin_s[sps_pkg::PIN_SCK];
      if (!master_select_on || (data_load && !m_act_q)) begin
        m_act_q <= master_select_on;
        hc_q    <= 5'h00;
        div_q   <= 8'h00;
        sck_q   <= cpol;
      end else if (m_act_q) begin
        div_q <= tick ? 8'h00 : div_q + 8'h01;
        if (m_edge) begin
          sck_q <= ~sck_q;
          hc_q  <= hc_q + 5'h01;
        end else if (tick) begin
          m_act_q <= 1'b0;
        end
      end
    end
  end

  // slave edges from the synchronised clock pin
  wire s_rise = pin_s[sps_pkg::PIN_SCK] & ~sck_p_q;
  wire s_fall = ~pin_s[sps_pkg::PIN_SCK] & sck_p_q;

  assign xf.load  = data_load;
  assign xf.wdata = wd;
  assign xf.cpha  = ctrl_q[sps_pkg::C1_CPHA];
  assign xf.lsbf  = ctrl_q[sps_pkg::C1_LSBF];
  assign xf.lead  = master_select_on ? m_lead : slv_sel & (cpol ? s_fall : s_rise);
  assign xf.trail = master_select_on ? m_trail : slv_sel & (cpol ? s_rise : s_fall);
  assign xf.abort = ~master_select_on & ~slv_sel;
  assign xf.sin   = master_select_on ? pin_s[sps_pkg::PIN_MISO] : pin_s[sps_pkg::PIN_MOSI];

  ////////////////////////////////////////////////////////////////////////
  // pin ownership
  wire [7:0] oe_d;
  wire [7:0] out_d;
  wire [7:0] pu_grp;
  wire [7:0] rd_grp;

  assign oe_d[0]  = sci_rx_two_wire[0] ? 1'b0 : dir_q[0];
  assign oe_d[2]  = sci_rx_two_wire[1] ? 1'b0 : dir_q[2];
  assign oe_d[1]  = sci_tx_two_wire[0] | dir_q[1];
  assign oe_d[3]  = sci_tx_two_wire[1] | dir_q[3];
  assign out_d[0] = latch_q[0];
  assign out_d[2] = latch_q[2];
  assign out_d[1] = sci_tx_two_wire[0] ? sci_txd[0] : latch_q[1];
  assign out_d[3] = sci_tx_two_wire[1] ? sci_txd[1] : latch_q[3];
  assign oe_d[4]  = spi_on ? ~master_select & dir_q[4] & ~pin_s[sps_pkg::PIN_SEL] : dir_q[4];
  assign oe_d[5]  = spi_on ? master_select & dir_q[5] : dir_q[5];
  assign oe_d[6]  = spi_on ? master_select & dir_q[6] : dir_q[6];
  assign oe_d[7]  = (spi_on & ~master_select) ? 1'b0 : dir_q[7];
  assign out_d[4] = spi_on ? xf.sout : latch_q[4];
  assign out_d[5] = spi_on ? xf.sout : latch_q[5];
  assign out_d[6] = spi_on ? sck_q : latch_q[6];
  assign out_d[7] = (master_select_on & ssoe) ? ~m_act_q : latch_q[7];

  assign pu_grp = {{4{port_pullup_drive_control_q[sps_pkg::PD_PU_HIGH]}}, {2{port_pullup_drive_control_q[sps_pkg::PD_PU_MID]}},
                   {2{port_pullup_drive_control_q[sps_pkg::PD_PU_LOW]}}};
  assign rd_grp = {{4{port_pullup_drive_control_q[sps_pkg::PD_RD_HIGH]}}, {2{port_pullup_drive_control_q[sps_pkg::PD_RD_MID]}},
                   {2{port_pullup_drive_control_q[sps_pkg::PD_RD_LOW]}}};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_oe            <= 8'h00;
      pin_out           <= 8'h00;
      pin_pullup_en     <= 8'h00;
      pin_drive_reduced <= 8'h00;
      sci_rxd           <= 2'h3;
    end else begin
      pin_oe            <= oe_d;
      pin_out           <= out_d;
      pin_pullup_en     <= pu_grp & ~oe_d;
      pin_drive_reduced <= rd_grp;
      sci_rxd           <= {pin_s[sps_pkg::PIN_RX1], pin_s[sps_pkg::PIN_RX0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_write_collision_flag_on_busy: assert property (@(posedge sys_clk) disable iff (rst)
    wr_c && hit_data && xfer_busy |=> write_collision_flag_q && !$rose(m_act_q))
    else $error("busy data write did not raise collision");
  chk_write_collision_flag_no_irq: assert property (@(posedge sys_clk) disable iff (rst)
    (!transfer_done_flag_q && !mode_fault_flag_q)[*2] |-> !spi_irq)
    else $error("interrupt raised without done or fault");
  // checker memory: last status read saw the collision flag, no data access since
  logic seen_write_collision_flag_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_write_collision_flag_q <= 1'b0;
    end else if (rd_c && hit_stat) begin
      seen_write_collision_flag_q <= write_collision_flag_q;
    end else if (data_acc) begin
      seen_write_collision_flag_q <= 1'b0;
    end
  end

  chk_write_collision_flag_clear_seq: assert property (@(posedge sys_clk) disable iff (rst)
    seen_write_collision_flag_q && data_acc && !write_collision_flag_set |=> !write_collision_flag_q)
    else $error("collision flag not cleared by status read then data access");
  chk_mode_fault_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    !mode_fault_flag_q && serial_system_enable && master_select && !dir_q[7] && !pin_s[7] |=> mode_fault_flag_q)
    else $error("mode fault not flagged");
  chk_mode_fault_flag_inhibit: assert property (@(posedge sys_clk) disable iff (rst)
    dir_q[7] |-> !mode_fault_flag_q)
    else $error("fault flag set while select pin is output");
  chk_mode_fault_flag_hold: assert property (@(posedge sys_clk) disable iff (rst)
    mode_fault_flag_q && !ctrl_wr && !dir_wr |=> mode_fault_flag_q)
    else $error("fault flag cleared without control write");
  chk_fault_dir: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(mode_fault_flag_q) |-> dir_q[7:5] == 3'h0)
    else $error("fault did not clear direction bits");
  chk_reset_pins: assert property (@(posedge sys_clk)
    $past(rst) |-> pin_oe == 8'h00 && dir_q == 8'h00)
    else $error("pins not inputs after reset");
  chk_done_flag: assert property (@(posedge sys_clk) disable iff (rst)
    xf.done |=> transfer_done_flag_q ##1 (ie -> spi_irq))
    else $error("done flag or request missing after byte");
  chk_pullup_out: assert property (@(posedge sys_clk) disable iff (rst)
    (pin_pullup_en & pin_oe) == 8'h00)
    else $error("pull-up active on output pin");
  chk_tx_force: assert property (@(posedge sys_clk) disable iff (rst)
    sci_tx_two_wire[0] |=> pin_oe[1] && pin_out[1] == $past(sci_txd[0]))
    else $error("transmit pin not forced to output");
endmodule : sps_port_spi
`default_nettype wire

// ==== tb/sps_slave_model.sv ====
// Purpose: behavioural slave on the serial link, clock format zero
// Assumes: select active low, data most significant bit first
// Notes:   a released output shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module sps_slave_model (
  // link
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // bytes
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh;
  logic       bit_in;
  initial miso = 1'b1;
  always @(negedge ss_n) begin
    sh   = tx_byte;
    miso = tx_byte[7];
  end
  always @(posedge sck) if (!ss_n) bit_in = mosi;
  always @(negedge sck) begin
    if (!ss_n) begin
      sh   = {sh[6:0], bit_in};
      miso = sh[7];
    end
  end
  // deselected: no stale level for the simulator to settle
  always @(posedge ss_n) begin
    rx_byte = sh;
    miso    = ~miso;
  end
endmodule : sps_slave_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the serial flags, data register and port
// Assumes: one wait cycle per bus access, rate index two for master transfers
// Notes:   pin levels are resolved here from drive enables and bench levels
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [7:0] CT = sps_pkg::REG_CTRL1;
  localparam logic [7:0] BR = sps_pkg::REG_BAUD;
  localparam logic [7:0] ST = sps_pkg::REG_STAT;
  localparam logic [7:0] DA = sps_pkg::REG_DATA;
  localparam logic [7:0] PT = sps_pkg::REG_PORT;
  localparam logic [7:0] DR = sps_pkg::REG_DIR;
  localparam logic [7:0] PD = sps_pkg::REG_PORT_PULLUP_DRIVE_CONTROL;
  typedef struct packed {
    logic [7:0] dir, dat, drv, pd;
    logic [3:0] tw;
    logic [7:0] oe, ot, rd, pu, dr;
  } sps_row_t;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup_en, pin_drive_reduced;
  logic [7:0]  drv = 8'hff;
  logic [1:0]  rx_tw = 2'h0;
  logic [1:0]  tx_tw = 2'h0;
  logic [1:0]  sci_rxd;
  logic        spi_irq, miso;
  logic        use_slave = 1'b0;
  logic [7:0]  slv_rx, q, got;
  logic [7:0]  sb = 8'h6e;
  int          n_fail = 0;
  int          num_checks = 0;
  sps_row_t    rows [4] = '{
    '{8'h0f, 8'ha5, 8'h3c, 8'hff, 4'h0, 8'h0f, 8'h05, 8'h35, 8'hf0, 8'hff},
    '{8'hf0, 8'h5a, 8'hc3, 8'h12, 4'h0, 8'hf0, 8'h50, 8'h53, 8'h0c, 8'h03},
    '{8'h33, 8'h0f, 8'hff, 8'h45, 4'h0, 8'h33, 8'h03, 8'hcf, 8'hc0, 8'hf0},
    '{8'h05, 8'h00, 8'h55, 8'h00, 4'hf, 8'h0a, 8'h0a, 8'h5f, 8'h00, 8'h00}};
  always #4 sys_clk = ~sys_clk;
  always_comb begin
    pin_in = (pin_out & pin_oe) | (drv & ~pin_oe);
    if (use_slave && !pin_oe[4]) pin_in[4] = miso;
  end
  sps_port_spi dut (
    .sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .pin_drive_reduced(pin_drive_reduced),
    .sci_rx_two_wire(rx_tw), .sci_tx_two_wire(tx_tw), .sci_txd(2'h3),
    .sci_rxd(sci_rxd), .spi_irq(spi_irq));
  sps_slave_model slv (
    .ss_n(pin_in[7]), .sck(pin_in[6]), .mosi(pin_in[5]), .miso(miso),
    .tx_byte(8'h3c), .rx_byte(slv_rx));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask : chk
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(pin_oe, 8'h00);
    rd(DR, 8'h00);
    rd(8'h10, 8'h00);
    foreach (rows[i]) begin
      {rx_tw, tx_tw} <= rows[i].tw;
      drv <= rows[i].drv;
      bus(1'b1, DR, rows[i].dir);
      bus(1'b1, PT, rows[i].dat);
      bus(1'b1, PD, rows[i].pd);
      repeat (4) @(posedge sys_clk);
      rd(PT, rows[i].rd);
      rd(PD, rows[i].pd & 8'h77);
      chk(pin_oe, rows[i].oe);
      chk(pin_out & pin_oe, rows[i].ot);
      chk(pin_pullup_en, rows[i].pu);
      chk(pin_drive_reduced, rows[i].dr);
      chk({6'h00, sci_rxd}, {6'h00, rows[i].rd[2], rows[i].rd[0]});
    end
    // master byte with a colliding write in mid-transfer
    {rx_tw, tx_tw} <= 4'h0;
    drv <= 8'hff;
    use_slave <= 1'b1;
    bus(1'b1, PD, 8'h00);
    bus(1'b1, BR, 8'h02);
    bus(1'b1, DR, 8'he0);
    bus(1'b1, CT, 8'hd2);
    bus(1'b1, DA, 8'ha5);
    bus(1'b1, DA, 8'hff);
    chk({7'h0, spi_irq}, 8'h00);
    q = 8'h00;
    for (int i = 0; i < 100 && q[7] !== 1'b1; i++) bus(1'b0, ST, 8'h00);
    chk(q, 8'hc0);
    chk({7'h0, spi_irq}, 8'h01);
    rd(DA, 8'h3c);
    rd(ST, 8'h00);
    chk(slv_rx, 8'ha5);
    chk({7'h0, spi_irq}, 8'h00);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(pin_oe, 8'h00);
    rd(DR, 8'h00);
    rd(DA, 8'h3c);
    // fault only when the select pin is an input
    use_slave <= 1'b0;
    bus(1'b1, CT, 8'h50);
    bus(1'b1, DR, 8'he0);
    drv <= 8'h7f;
    repeat (6) @(posedge sys_clk);
    rd(ST, 8'h00);
    bus(1'b1, DR, 8'h60);
    repeat (6) @(posedge sys_clk);
    rd(DR, 8'h00);
    rd(CT, 8'h10);
    drv <= 8'hff;
    rd(DA, 8'h3c);
    // no status read yet, so this control write must leave the fault standing
    bus(1'b1, CT, 8'h50);
    rd(ST, 8'h10);
    rd(CT, 8'h10);
    bus(1'b1, CT, 8'h50);
    rd(ST, 8'h00);
    // slave byte on an 80 ns link clock
    bus(1'b1, CT, 8'h40);
    bus(1'b1, DR, 8'h90);
    bus(1'b1, DA, 8'h81);
    got = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      drv <= {2'b00, sb[b], 5'h1f};
      repeat (5) @(posedge sys_clk);
      got[b] = pin_out[4];
      drv[6] <= 1'b1;
      repeat (5) @(posedge sys_clk);
    end
    drv <= 8'h1f;
    repeat (5) @(posedge sys_clk);
    chk(pin_oe, 8'h10);
    chk(got, 8'h81);
    drv <= 8'hff;
    repeat (6) @(posedge sys_clk);
    rd(ST, 8'h80);
    rd(DA, 8'h6e);
    results();
  end
endmodule : tb
`default_nettype wire
